// *** l2dc_defs.svh ***
`ifndef L2DC_DEFS_SVH
`define L2DC_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define L2DC_OFS_CTRL 8'h00
`define L2DC_OFS_ARITH 8'h04
`define L2DC_OFS_MSTAT 8'h08
`define L2DC_OFS_CSTAT 8'h0C
`define L2DC_OFS_CADDR_LO 8'h10
`define L2DC_OFS_CADDR_HI 8'h14
`define L2DC_OFS_MADDR_LO 8'h18
`define L2DC_OFS_MADDR_HI 8'h1C

// ****************************************************************
// field positions and masks
// ****************************************************************
`define L2DC_CTRL_DM 0
`define L2DC_CTRL_DIS 1
`define L2DC_CTRL_CACHE_CEEN 2
`define L2DC_CTRL_CORE_CEEN 3
`define L2DC_CTRL_MASK 32'h0000_1F0F
`define L2DC_ARITH_INT 0
`define L2DC_ARITH_MASK 32'h0000_1F01
`define L2DC_STRAND_LSB 8
`define L2DC_MST_DAC 0
`define L2DC_MST_DSC 1
`define L2DC_MST_MEC 2
`define L2DC_CST_DAC 0
`define L2DC_CST_DRC 1
`define L2DC_CST_DSC 2
`define L2DC_CST_MEC 3

// ****************************************************************
// reset values and geometry
// ****************************************************************
`define L2DC_CTRL_RST 32'h0000_000C
`define L2DC_ARITH_RST 32'h0000_0000
`define L2DC_WAYS 12
`define L2DC_SETS 16
`define L2DC_RESP_OKAY 2'h0
`define L2DC_RESP_SLVERR 2'h2

`endif

// *** l2dc_pkg.sv ***
package l2dc_pkg;

   // access kind reported with each memory reply
   typedef enum logic [3:0] {
      L2DC_PF,
      L2DC_LD,
      L2DC_IF,
      L2DC_ATOM,
      L2DC_PST,
      L2DC_ST,
      L2DC_MA_LD,
      L2DC_DMA_RD,
      L2DC_DMA_PW,
      L2DC_SCRUB
   } l2dc_kind_t;

   typedef logic [4:0] l2dc_strand_t;
   typedef logic [3:0] l2dc_way_t;

endpackage : l2dc_pkg

// *** l2dc_nibble_fix.sv ***
`timescale 1ns/1ps

// ****************************************************************
// single nibble repair of a 128-bit block
// ****************************************************************
module l2dc_nibble_fix (
   // reported block and failing nibble
   input wire logic [127:0] data_in,
   input wire logic [4:0] nib_idx,
   input wire logic [3:0] nib_mask,
   // repaired block
   output logic [127:0] data_out
);
   // flip the bad bits of the one aligned nibble named
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_nib
         assign data_out[4*g +: 4] = (nib_idx == 5'(g)) ?
            (data_in[4*g +: 4] ^ nib_mask) : data_in[4*g +: 4];
      end
   endgenerate
endmodule : l2dc_nibble_fix

// *** l2dc_victim_sel.sv ***
`timescale 1ns/1ps
`include "l2dc_defs.svh"

// ****************************************************************
// victim way choice: bit pseudo-lru or direct mapped
// ****************************************************************
module l2dc_victim_sel
   import l2dc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // mode and request
   input wire logic dm_mode,
   input wire logic repl_req,
   input wire logic [3:0] repl_set,
   input wire logic [3:0] repl_tag,
   // hit touches from lookups in either mode
   input wire logic touch_valid,
   input wire logic [3:0] touch_set,
   input wire l2dc_way_t touch_way,
   // chosen way
   output logic victim_valid,
   output l2dc_way_t victim_way
);
   logic [`L2DC_WAYS-1:0] mru_q [`L2DC_SETS];
   l2dc_way_t plru_way;
   l2dc_way_t dm_way;

   // first way whose recently-used bit is clear
   always_comb begin
      plru_way = '0;
      for (int w = `L2DC_WAYS - 1; w >= 0; w--) begin
         if (!mru_q[repl_set][w]) begin
            plru_way = 4'(w);
         end
      end
   end

   // address bits fold onto the twelve ways
   assign dm_way = 4'(repl_tag % 4'(`L2DC_WAYS));

   // mru bits; reset others once all would be set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int s = 0; s < `L2DC_SETS; s++) begin
            mru_q[s] <= '0;
         end
      end else if (touch_valid) begin
         if ((mru_q[touch_set] | (12'(1) << touch_way)) == {`L2DC_WAYS{1'b1}}) begin
            mru_q[touch_set] <= 12'(1) << touch_way;
         end else begin
            mru_q[touch_set] <= mru_q[touch_set] | (12'(1) << touch_way);
         end
      end
   end

   // registered answer, one cycle after the request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         victim_valid <= 1'b0;
         victim_way <= '0;
      end else begin
         victim_valid <= repl_req;
         victim_way <= dm_mode ? dm_way : plru_way;
      end
   end
endmodule : l2dc_victim_sel

// *** l2dc_top.sv ***
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "l2dc_defs.svh"

// How it works
// - twelve-way cache, victims chosen by pseudo-lru, no flush operation
// - direct-mapped mode picks the victim from address bits instead
// - hits match regardless of mode at insert, mode may change live
// - each 128-bit block repairs any one failed aligned nibble
// - cache disabled: full stores neither log cache status nor trap
// - prefetch logs all three; traps steered only outside block
// - fill data is always corrected before it is written
// - in-block error returned before fill traps requester, else steered
// - errors inside before fill and outside block trap both requester and steered
// - partial store logs, traps steered, merges store into corrected data
// - full store always logs memory status, cache logs only if enabled
// - arith load logs, returns fixed data, flags unit when enabled
// - arith done traps completion strand or sync strand by mode
// - dma read logs, returns fixed data, traps steered strand
// - dma partial write fixes line, logs all three, traps steered
// - dma errors record dma-correctable code in cache status
// - scrub logs memory regs, sets scrub bit, writes back, traps
// - status bits are cleared only by software writes
module l2dc_top
   import l2dc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // memory controller reply
   input wire logic mc_valid,
   input wire l2dc_kind_t mc_kind,
   input wire logic mc_ce,
   input wire logic [127:0] mc_data,
   input wire logic [4:0] mc_nib_idx,
   input wire logic [3:0] mc_nib_mask,
   input wire logic [39:4] mc_addr,
   input wire logic mc_in_block,
   input wire logic mc_out_block,
   input wire logic mc_before_fill,
   input wire l2dc_strand_t mc_req_strand,
   // partial store data for merge
   input wire logic [127:0] st_data,
   input wire logic [15:0] st_be,
   // arithmetic unit completion
   input wire logic arith_done,
   input wire l2dc_strand_t arith_sync_strand,
   // replacement and hit touches
   input wire logic repl_req,
   input wire logic [3:0] repl_set,
   input wire logic [3:0] repl_tag,
   input wire logic touch_valid,
   input wire logic [3:0] touch_set,
   input wire l2dc_way_t touch_way,
   output logic victim_valid,
   output l2dc_way_t victim_way,
   // corrected data returns
   output logic fill_valid,
   output logic dma_rsp_valid,
   output logic arith_rsp_valid,
   output logic arith_ce,
   output logic scrub_wb_valid,
   output logic [127:0] rsp_data,
   // trap requests
   output logic steer_trap_valid,
   output l2dc_strand_t steer_trap_strand,
   output logic req_trap_valid,
   output l2dc_strand_t req_trap_strand,
   output logic arith_trap_valid,
   output l2dc_strand_t arith_trap_strand
);
   // ****************************************************************
   // registers and common terms
   // ****************************************************************
   logic [31:0] ctrl_q;
   logic [31:0] arith_q;
   logic [2:0] mstat_q;
   logic [3:0] cstat_q;
   logic [39:4] caddr_q;
   logic [39:4] maddr_q;
   logic aw_got_q;
   logic w_got_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic arith_pend_q;
   logic [127:0] fixed_data;
   logic [127:0] merged_data;
   logic [31:0] wmask;
   logic [31:0] rd_val;
   logic rd_ok;
   logic wr_go;
   logic ev;
   logic trap_en;
   logic is_dma;
   logic is_scrub;
   logic is_ld;
   logic full_st_off;
   logic cache_log;
   logic do_steer;
   logic do_req;
   logic [2:0] mclr;
   logic [3:0] cclr;
   logic [2:0] mset;
   logic [3:0] cset;

   // repair the reported nibble
   l2dc_nibble_fix u_fix (
      .data_in(mc_data),
      .nib_idx(mc_nib_idx),
      .nib_mask(mc_nib_mask),
      .data_out(fixed_data)
   );

   // victim way choice
   l2dc_victim_sel u_victim (
      .aclk(aclk),
      .aresetn(aresetn),
      .dm_mode(ctrl_q[`L2DC_CTRL_DM]),
      .repl_req(repl_req),
      .repl_set(repl_set),
      .repl_tag(repl_tag),
      .touch_valid(touch_valid),
      .touch_set(touch_set),
      .touch_way(touch_way),
      .victim_valid(victim_valid),
      .victim_way(victim_way)
   );

   // event classification
   assign ev = mc_valid && mc_ce;
   assign trap_en = ctrl_q[`L2DC_CTRL_CACHE_CEEN] && ctrl_q[`L2DC_CTRL_CORE_CEEN];
   assign is_dma = (mc_kind == L2DC_DMA_RD) || (mc_kind == L2DC_DMA_PW);
   assign is_scrub = (mc_kind == L2DC_SCRUB);
   assign is_ld = (mc_kind == L2DC_LD) || (mc_kind == L2DC_IF) || (mc_kind == L2DC_ATOM);
   assign full_st_off = (mc_kind == L2DC_ST) && ctrl_q[`L2DC_CTRL_DIS];
   assign cache_log = ev && !is_scrub && !full_st_off;

   // trap steering per access kind
   always_comb begin
      do_steer = 1'b0;
      unique case (mc_kind)
         L2DC_PF: do_steer = trap_en && mc_out_block;
         L2DC_LD, L2DC_IF, L2DC_ATOM:
            do_steer = trap_en && (mc_out_block || !(mc_in_block && mc_before_fill));
         L2DC_MA_LD: do_steer = 1'b0;
         L2DC_ST: do_steer = trap_en && !ctrl_q[`L2DC_CTRL_DIS];
         L2DC_PST, L2DC_DMA_RD, L2DC_DMA_PW, L2DC_SCRUB: do_steer = trap_en;
         default: do_steer = 1'b0;
      endcase
   end
   assign do_req = trap_en && is_ld && mc_in_block && mc_before_fill;

   // partial store bytes land on corrected data
   genvar b;
   generate
      for (b = 0; b < 16; b++) begin : g_merge
         assign merged_data[8*b +: 8] = st_be[b] ? st_data[8*b +: 8] : fixed_data[8*b +: 8];
      end
   endgenerate

   // ****************************************************************
   // axi4-lite slave
   // ****************************************************************
   assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign mclr = (wr_go && awaddr_q == `L2DC_OFS_MSTAT) ? (wdata_q[2:0] & wmask[2:0]) : 3'h0;
   assign cclr = (wr_go && awaddr_q == `L2DC_OFS_CSTAT) ? (wdata_q[3:0] & wmask[3:0]) : 4'h0;

   // address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wr_go) begin
            aw_got_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_got_q <= 1'b0;
         end
      end
   end

   // write response after both halves
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `L2DC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_q <= `L2DC_OFS_MADDR_HI) ? `L2DC_RESP_OKAY : `L2DC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
         `L2DC_OFS_CTRL: rd_val = ctrl_q;
         `L2DC_OFS_ARITH: rd_val = arith_q;
         `L2DC_OFS_MSTAT: rd_val = {29'h0, mstat_q};
         `L2DC_OFS_CSTAT: rd_val = {28'h0, cstat_q};
         `L2DC_OFS_CADDR_LO: rd_val = {caddr_q[31:4], 4'h0};
         `L2DC_OFS_CADDR_HI: rd_val = {24'h0, caddr_q[39:32]};
         `L2DC_OFS_MADDR_LO: rd_val = {maddr_q[31:4], 4'h0};
         `L2DC_OFS_MADDR_HI: rd_val = {24'h0, maddr_q[39:32]};
         default: rd_ok = 1'b0;
      endcase
   end

   // read channel, answer the cycle after arready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `L2DC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? `L2DC_RESP_OKAY : `L2DC_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // control registers with byte strobes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `L2DC_CTRL_RST;
         arith_q <= `L2DC_ARITH_RST;
      end else if (wr_go && awaddr_q == `L2DC_OFS_CTRL) begin
         ctrl_q <= ((ctrl_q & ~wmask) | (wdata_q & wmask)) & `L2DC_CTRL_MASK;
      end else if (wr_go && awaddr_q == `L2DC_OFS_ARITH) begin
         arith_q <= ((arith_q & ~wmask) | (wdata_q & wmask)) & `L2DC_ARITH_MASK;
      end
   end

   // ****************************************************************
   // error logging
   // ****************************************************************
   // a new error on a live log marks the multiple bit instead
   always_comb begin
      mset = 3'h0;
      cset = 4'h0;
      if (ev) begin
         if (mstat_q[`L2DC_MST_DAC] || mstat_q[`L2DC_MST_DSC]) begin
            mset[`L2DC_MST_MEC] = 1'b1;
         end else if (is_scrub) begin
            mset[`L2DC_MST_DSC] = 1'b1;
         end else begin
            mset[`L2DC_MST_DAC] = 1'b1;
         end
      end
      if (cache_log || (ev && is_scrub)) begin
         if (cstat_q[2:0] != 3'h0) begin
            cset[`L2DC_CST_MEC] = 1'b1;
         end else if (is_scrub) begin
            cset[`L2DC_CST_DSC] = 1'b1;
         end else if (is_dma) begin
            cset[`L2DC_CST_DRC] = 1'b1;
         end else begin
            cset[`L2DC_CST_DAC] = 1'b1;
         end
      end
   end

   // sticky status, a same-cycle error beats the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mstat_q <= '0;
         cstat_q <= '0;
      end else begin
         mstat_q <= (mstat_q & ~mclr) | mset;
         cstat_q <= (cstat_q & ~cclr) | cset;
      end
   end

   // address capture for the first logged error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         caddr_q <= '0;
         maddr_q <= '0;
      end else begin
         if (cache_log && cstat_q[2:0] == 3'h0) begin
            caddr_q <= mc_addr;
         end
         if (ev && mstat_q[1:0] == 2'h0) begin
            maddr_q <= mc_addr;
         end
      end
   end

   // ****************************************************************
   // corrected data returns
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fill_valid <= 1'b0;
         dma_rsp_valid <= 1'b0;
         arith_rsp_valid <= 1'b0;
         arith_ce <= 1'b0;
         scrub_wb_valid <= 1'b0;
         rsp_data <= '0;
      end else begin
         fill_valid <= mc_valid && !is_scrub && (mc_kind != L2DC_DMA_RD);
         dma_rsp_valid <= mc_valid && (mc_kind == L2DC_DMA_RD);
         arith_rsp_valid <= mc_valid && (mc_kind == L2DC_MA_LD);
         arith_ce <= ev && (mc_kind == L2DC_MA_LD) && ctrl_q[`L2DC_CTRL_CACHE_CEEN];
         scrub_wb_valid <= ev && is_scrub;
         rsp_data <= (mc_kind == L2DC_PST) ? merged_data : fixed_data;
      end
   end

   // ****************************************************************
   // trap requests
   // ****************************************************************
   // corrected-error flag held for the arithmetic unit until it completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arith_pend_q <= 1'b0;
      end else if (ev && mc_kind == L2DC_MA_LD && ctrl_q[`L2DC_CTRL_CACHE_CEEN]) begin
         arith_pend_q <= 1'b1;
      end else if (arith_done) begin
         arith_pend_q <= 1'b0;
      end
   end

   // one-cycle pulses with the target strand
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         steer_trap_valid <= 1'b0;
         steer_trap_strand <= '0;
         req_trap_valid <= 1'b0;
         req_trap_strand <= '0;
         arith_trap_valid <= 1'b0;
         arith_trap_strand <= '0;
      end else begin
         steer_trap_valid <= ev && do_steer;
         steer_trap_strand <= ctrl_q[`L2DC_STRAND_LSB +: 5];
         req_trap_valid <= ev && do_req;
         req_trap_strand <= mc_req_strand;
         arith_trap_valid <= arith_done && arith_pend_q && ctrl_q[`L2DC_CTRL_CORE_CEEN];
         arith_trap_strand <= arith_q[`L2DC_ARITH_INT] ?
            arith_q[`L2DC_STRAND_LSB +: 5] : arith_sync_strand;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_arith_flagged;
      ev && mc_kind == L2DC_MA_LD && ctrl_q[`L2DC_CTRL_CACHE_CEEN] && !arith_done;
   endsequence
   sequence s_arith_finish;
      arith_done && ctrl_q[`L2DC_CTRL_CORE_CEEN] && !arith_q[`L2DC_ARITH_INT];
   endsequence

   a_arith_sync_trap: assert property (s_arith_flagged ##1 s_arith_finish
      |=> arith_trap_valid && arith_trap_strand == $past(arith_sync_strand))
      else $error("arith completion did not trap sync strand");
   a_store_disabled: assert property (ev && full_st_off
      |=> !steer_trap_valid && !req_trap_valid)
      else $error("disabled-cache store raised a trap");
   a_prefetch_inside: assert property (ev && mc_kind == L2DC_PF && !mc_out_block
      |=> !steer_trap_valid)
      else $error("in-block prefetch error trapped");
   a_fill_corrected: assert property (mc_valid && is_ld
      |=> fill_valid && rsp_data == $past(fixed_data))
      else $error("fill data not corrected");
   a_both_traps: assert property (ev && trap_en && is_ld && mc_in_block && mc_out_block
      && mc_before_fill
      |=> steer_trap_valid && req_trap_valid && req_trap_strand == $past(mc_req_strand))
      else $error("split error did not trap both strands");
   a_dma_read_trap: assert property (ev && trap_en && mc_kind == L2DC_DMA_RD
      |=> dma_rsp_valid && steer_trap_valid
      && steer_trap_strand == $past(ctrl_q[`L2DC_STRAND_LSB +: 5]))
      else $error("dma read error not steered");
   a_dma_code: assert property (ev && is_dma && cstat_q == 4'h0
      |=> cstat_q[`L2DC_CST_DRC] && !cstat_q[`L2DC_CST_DAC])
      else $error("dma error logged with wrong code");
   a_scrub_log: assert property (ev && is_scrub && mstat_q == 3'h0 && cstat_q[2:0] == 3'h0
      |=> scrub_wb_valid && mstat_q[`L2DC_MST_DSC] && cstat_q[`L2DC_CST_DSC])
      else $error("scrub error not logged or written back");
   a_status_sticky: assert property ($fell(cstat_q[`L2DC_CST_DAC])
      |-> $past(cclr[`L2DC_CST_DAC]))
      else $error("status bit cleared without software");
   a_trap_pulse: assert property (steer_trap_valid && !$past(ev)
      |-> 1'b0)
      else $error("steered trap without an error event");
endmodule : l2dc_top

// *** l2dc_mc_model.sv ***
`timescale 1ns/1ps
// ****
// memory reply model
// ****
module l2dc_mc_model import l2dc_pkg::*; (
   // clock
   input wire logic aclk,
   // reply beat
   output logic mc_valid = '0,
   output l2dc_kind_t mc_kind = L2DC_PF,
   output logic mc_ce = '0,
   output logic [127:0] mc_data = '0,
   output logic [4:0] mc_nib_idx = '0,
   output logic [3:0] mc_nib_mask = '0,
   output logic [39:4] mc_addr = '0,
   output logic mc_in_block = '0,
   output logic mc_out_block = '0,
   output logic mc_before_fill = '0,
   output l2dc_strand_t mc_req_strand = '0
);
   // one beat, then data toggles so a stale block never looks valid
   task automatic send(input l2dc_kind_t k, input logic ib, ob, bf, input logic [127:0] d,
                       input logic [4:0] i, input logic [3:0] m, input l2dc_strand_t rs);
      mc_valid <= '1;
      mc_kind <= k;
      mc_ce <= '1;
      mc_data <= d;
      mc_nib_idx <= i;
      mc_nib_mask <= m;
      mc_addr <= 36'({$urandom, $urandom});
      mc_in_block <= ib;
      mc_out_block <= ob;
      mc_before_fill <= bf;
      mc_req_strand <= rs;
      @(posedge aclk);
      mc_valid <= '0;
      mc_data <= ~d;
   endtask : send
endmodule : l2dc_mc_model

// *** tb_top.sv ***
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_top import l2dc_pkg::*; ;
   logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0, arith_done = '0, repl_req = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] repl_tag = '0, repl_set = '0, mc_nib_mask;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic mc_valid, mc_ce, mc_in_block, mc_out_block, mc_before_fill, victim_valid;
   logic fill_valid, dma_rsp_valid, arith_rsp_valid, arith_ce, scrub_wb_valid;
   logic steer_trap_valid, req_trap_valid, arith_trap_valid;
   logic [127:0] mc_data, rsp_data;
   logic [4:0] mc_nib_idx;
   logic [39:4] mc_addr;
   l2dc_kind_t mc_kind;
   l2dc_way_t victim_way;
   l2dc_strand_t arith_sync_strand = '0, mc_req_strand, steer_trap_strand, req_trap_strand;
   l2dc_strand_t arith_trap_strand, st;
   int mismatches = 0, num_checks = 0, cyc = 0;
   l2dc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mc_valid, .mc_kind, .mc_ce,
      .mc_data, .mc_nib_idx, .mc_nib_mask, .mc_addr, .mc_in_block, .mc_out_block,
      .mc_before_fill, .mc_req_strand, .st_data(128'h0), .st_be(16'h0000), .arith_done,
      .arith_sync_strand, .repl_req, .repl_set, .repl_tag, .touch_valid(victim_valid),
      .touch_set(repl_set), .touch_way(victim_way), .victim_valid, .victim_way, .fill_valid,
      .dma_rsp_valid, .arith_rsp_valid, .arith_ce, .scrub_wb_valid, .rsp_data,
      .steer_trap_valid, .steer_trap_strand, .req_trap_valid, .req_trap_strand,
      .arith_trap_valid, .arith_trap_strand);
   l2dc_mc_model u_mc (.aclk, .mc_valid, .mc_kind, .mc_ce, .mc_data, .mc_nib_idx,
      .mc_nib_mask, .mc_addr, .mc_in_block, .mc_out_block, .mc_before_fill, .mc_req_strand);
   // clock and hang limit
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   task print_verdict;
      if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic chk(input string n, input logic [127:0] e, v);
      num_checks++;
      if (v !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, v);
      end
   endtask : chk
   // register bus write and read
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= '1;
      s_axi_wvalid <= '1;
      s_axi_bready <= '1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= '0;
         if (s_axi_wready) s_axi_wvalid <= '0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= '0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= '1;
      s_axi_rready <= '1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= '0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= '0;
   endtask : rdr
   // one reply with expected traps
   task automatic beat(input l2dc_kind_t k, input logic ib, ob, bf, er, es);
      logic [127:0] d;
      logic [4:0] i;
      logic [3:0] m;
      l2dc_strand_t rs;
      d = {$urandom, $urandom, $urandom, $urandom};
      i = 5'($urandom);
      m = 4'($urandom) | 4'h1;
      rs = 5'($urandom);
      @(posedge aclk);
      u_mc.send(k, ib, ob, bf, d, i, m, rs);
      @(negedge aclk);
      chk("rsp_data", d ^ (128'(m) << (4 * i)), rsp_data);
      chk("req_trap", er, req_trap_valid);
      chk("steer_trap", es, steer_trap_valid);
      if (es) chk("steer_strand", st, steer_trap_strand);
      if (er) chk("req_strand", rs, req_trap_strand);
      chk("arith_ce", k == L2DC_MA_LD, arith_ce);
      chk("rsp_valid", {k != L2DC_SCRUB && k != L2DC_DMA_RD, k == L2DC_DMA_RD, k == L2DC_MA_LD,
         k == L2DC_SCRUB}, {fill_valid, dma_rsp_valid, arith_rsp_valid, scrub_wb_valid});
   endtask : beat
   // one victim request; the answered way is touched back as a fill would
   task automatic vic(input logic [3:0] t, input l2dc_way_t w);
      @(posedge aclk);
      repl_req <= '1;
      repl_tag <= t;
      @(posedge aclk);
      repl_req <= '0;
      @(negedge aclk);
      chk("victim", {1'h1, w}, {victim_valid, victim_way});
   endtask : vic
   initial begin
      void'($urandom(32'h6925_0074));
      st = 5'($urandom);
      repeat (10) @(posedge aclk);
      aresetn <= '1;
      rdr(8'h00);
      chk("ctrl", 32'h0000_000C, rd);
      rdr(8'h20);
      chk("rresp", 2'h2, rsp);
      wr(8'h20, 32'h0000_0000);
      chk("bresp", 2'h2, rsp);
      wr(8'h00, {19'h0_0000, st, 8'h0D});
      // direct mapped victims across all tags of one set
      repl_set <= 4'($urandom);
      for (int t = 0; t < 16; t++) begin
         vic(4'(t), 4'(t % 12));
      end
      beat(L2DC_SCRUB, 0, 0, 0, 0, 1);
      wr(8'h0C, 32'h0000_000F);
      beat(L2DC_LD, 1, 0, 1, 1, 0);
      beat(L2DC_IF, 1, 0, 0, 0, 1);
      beat(L2DC_ATOM, 1, 1, 1, 1, 1);
      beat(L2DC_PF, 1, 0, 1, 0, 0);
      beat(L2DC_PF, 0, 1, 1, 0, 1);
      beat(L2DC_PST, 1, 0, 1, 0, 1);
      beat(L2DC_ST, 1, 0, 1, 0, 1);
      beat(L2DC_DMA_PW, 1, 0, 1, 0, 1);
      // completion right after the flagged load
      fork
         beat(L2DC_MA_LD, 1, 0, 1, 0, 0);
         begin
            repeat (2) @(posedge aclk);
            arith_done <= '1;
            arith_sync_strand <= 5'($urandom);
         end
      join
      @(posedge aclk);
      arith_done <= '0;
      @(negedge aclk);
      chk("arith_trap", {1'h1, arith_sync_strand}, {arith_trap_valid, arith_trap_strand});
      wr(8'h08, 32'h0000_0007);
      wr(8'h0C, 32'h0000_000F);
      wr(8'h00, {19'h0_0000, st, 8'h0E});
      // pseudo-lru resumes from the touches made in direct mode
      for (int t = 4; t < 11; t++) begin
         vic(4'($urandom), 4'(t));
      end
      vic(4'($urandom), 4'h0);
      beat(L2DC_ST, 1, 0, 1, 0, 0);
      rdr(8'h08);
      chk("mstat", 32'h0000_0001, rd);
      rdr(8'h0C);
      chk("cstat", 32'h0000_0000, rd);
      beat(L2DC_DMA_RD, 0, 1, 1, 0, 1);
      rdr(8'h0C);
      chk("cstat", 32'h0000_0002, rd);
      rdr(8'h08);
      chk("mstat", 32'h0000_0005, rd);
      print_verdict();
   end
endmodule : tb_top
